// ---- core/fpc_defines.svh ----
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
// ==========================================================
// Register map, byte addresses.
`define FPC_ADDR_CTRL 12'h000
`define FPC_ADDR_FREQ 12'h004
`define FPC_ADDR_VOLT 12'h008
`define FPC_ADDR_CURR 12'h00C
`define FPC_ADDR_STAT 12'h010
`define FPC_ADDR_KEYS 12'h014
`define FPC_ADDR_PARM 12'h018
// ==========================================================
// Control bit positions.
`define FPC_CTRL_FAULT 0
`define FPC_CTRL_TRIP 1
`define FPC_CTRL_EXT 2
`define FPC_CTRL_MANUAL 3
// ==========================================================
// Setpoint limits and reset values.
`define FPC_FREQ_PRESET 16'h0190
`define FPC_FREQ_MIN 16'h0168
`define FPC_FREQ_MAX 16'h01B8
`define FPC_FREQ_STEP 16'h0001
`define FPC_VOLT_RESET 16'h0000
`define FPC_VOLT_MAX_LO 16'h05DC
`define FPC_VOLT_MAX_HI 16'h0BB8
`define FPC_CURR_MIN 16'h0001
`define FPC_CURR_MAX_RESET 16'h00C8
`define FPC_PARM_MAX 8'h0F
// ==========================================================
// Timing: the clock rate and the times in their own units.
`define FPC_CLK_HZ 200000000
`define FPC_DEBOUNCE_US 10
`define FPC_REPEAT_MS 300
`define FPC_SETTLE_MS 2000
`define FPC_FLASH_MS 250
`define FPC_DEBOUNCE_CYC (`FPC_CLK_HZ / 1000000 * `FPC_DEBOUNCE_US)
`define FPC_REPEAT_CYC (`FPC_CLK_HZ / 1000 * `FPC_REPEAT_MS)
`define FPC_SETTLE_CYC (`FPC_CLK_HZ / 1000 * `FPC_SETTLE_MS)
`define FPC_FLASH_CYC (`FPC_CLK_HZ / 1000 * `FPC_FLASH_MS)
`endif

// ---- core/fpc_pkg.sv ----
`default_nettype none
package fpc_pkg;
    // Key indices on the key input bus.
    typedef enum logic [3:0] {
        FPC_K_F400 = 4'h0, FPC_K_FDN = 4'h1, FPC_K_FUP = 4'h2, FPC_K_LINE = 4'h3,
        FPC_K_RANGE = 4'h4, FPC_K_VDN = 4'h5, FPC_K_VUP = 4'h6, FPC_K_CDN = 4'h7,
        FPC_K_CUP = 4'h8, FPC_K_RECIPE = 4'h9, FPC_K_GLOBAL = 4'hA, FPC_K_FREEZE = 4'hB,
        FPC_K_READOUT = 4'hC, FPC_K_START = 4'hD, FPC_K_STOP = 4'hE, FPC_K_SPARE = 4'hF
    } fpc_key_t;
    typedef enum logic [1:0] {
        FPC_SET_NONE = 2'b00, FPC_SET_RECIPE = 2'b01, FPC_SET_GLOBAL = 2'b10
    } fpc_setup_t;
endpackage : fpc_pkg
`default_nettype wire

// ---- core/fpc_panel.sv ----
// Implementation choices: register access over APB and the address map.
`include "fpc_defines.svh"
`default_nettype none
// Function
// - The preset key loads the frequency setpoint with 400 Hz at once.
// - Frequency down key steps down, never below 360 Hz.
// - Frequency up key steps up, saturating at 440 Hz.
// - Output-on lamp lit exactly while output is delivered normally.
// - Fault lamp lights whenever an output error is detected.
// - Trip lamp lights when an error tripped protection, separate from fault.
// - Frequency display shows error on fault, parameters in setup, else frequency.
// - Line key cycles four voltage views with exactly one view lamp lit.
// - Low-range lamp for 0-150 V range, high-range lamp for 0-300 V range.
// - Range key toggles voltage range between high and low.
// - Voltage keys step voltage, or select the parameter in setup modes.
// - Current keys step limit or parameter value, and select status; limit bounded.
// - While locked the freeze lamp is lit and other keys do nothing.
// - Freeze key toggles the lock and leaves programmable mode.
// - External-control lamp lit while commanded by rear external inputs.
// - Hand-mode lamp lit while operating in manual mode.
// - Recipe key enters or leaves program setup; its lamp shows the mode.
// - Global key enters or leaves system setup; its lamp shows the mode.
// - Readout key cycles four readout_select_key views with exactly one lamp lit.
// - Start turns output on, stop gives standby; adjustments work in both.
// - Each frequency step is 1 Hz.
// - Held voltage key repeats every 0.3 s, accelerating while held.
// - Two seconds after a voltage change, flash once, store, leave setting mode.
module fpc_panel (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Panel keys, active high, asynchronous.
    input wire logic [15:0] keys,
    // Converter status, asynchronous.
    input wire logic output_active,
    // Setpoints and output control.
    output logic [15:0] freq_setpoint,
    output logic [15:0] volt_setpoint,
    output logic [15:0] volt_stored,
    output logic [15:0] curr_limit,
    output logic output_on_cmd,
    output logic range_high,
    // Displays.
    output logic [1:0] freq_disp_sel,
    output logic volt_blank,
    // Lamps.
    output logic lamp_output_on,
    output logic lamp_fault,
    output logic lamp_trip,
    output logic [3:0] lamp_line,
    output logic lamp_low_range,
    output logic lamp_high_range,
    output logic lamp_frozen,
    output logic lamp_external,
    output logic lamp_manual,
    output logic lamp_recipe,
    output logic lamp_global,
    output logic [3:0] lamp_readout
);
    // ==========================================================
    // Key synchronisers, debounce and press detection.
    localparam int DB_CYC = `FPC_DEBOUNCE_CYC;
    logic [15:0] key_s1;
    logic [15:0] key_s2;
    logic [15:0] key_db;
    logic [15:0] key_db_q;
    logic [15:0] press;
    logic [11:0] db_cnt [16];
    logic act_s1;
    logic act_s2;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            key_s1 <= 16'h0000;
            key_s2 <= 16'h0000;
            act_s1 <= 1'b0;
            act_s2 <= 1'b0;
        end else begin
            key_s1 <= keys;
            key_s2 <= key_s1;
            act_s1 <= output_active;
            act_s2 <= act_s1;
        end
    end

    // A level must hold for the whole debounce time before it is believed.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            key_db <= 16'h0000;
            key_db_q <= 16'h0000;
            for (int i = 0; i < 16; i++) db_cnt[i] <= 12'h000;
        end else begin
            key_db_q <= key_db;
            for (int i = 0; i < 16; i++) begin
                if (key_s2[i] == key_db[i]) begin
                    db_cnt[i] <= 12'h000;
                end else if (db_cnt[i] == 12'(DB_CYC - 1)) begin
                    key_db[i] <= key_s2[i];
                    db_cnt[i] <= 12'h000;
                end else begin
                    db_cnt[i] <= db_cnt[i] + 12'h001;
                end
            end
        end
    end

    logic locked;
    // Locked panels pass only the freeze key.
    always_comb begin
        press = key_db & ~key_db_q;
        if (locked) press = press & (16'h0001 << fpc_pkg::FPC_K_FREEZE);
    end

    // ==========================================================
    // Register file.
    logic [3:0] ctrl;
    logic [15:0] curr_max;
    logic wr;
    assign wr = psel && penable && pwrite;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= 4'h0;
            curr_max <= `FPC_CURR_MAX_RESET;
        end else if (wr && paddr == `FPC_ADDR_CTRL) begin
            ctrl <= pwdata[3:0];
        end else if (wr && paddr == `FPC_ADDR_CURR) begin
            curr_max <= pwdata[31:16];
        end
    end

    // ==========================================================
    // Modes: lock, setup, output.
    fpc_pkg::fpc_setup_t setup;
    logic [7:0] parm_sel;
    logic [7:0] parm_val;
    logic [1:0] line_view;
    logic [1:0] readout_select_key_view;
    logic [1:0] status_sel;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            locked <= 1'b0;
            setup <= fpc_pkg::FPC_SET_NONE;
            output_on_cmd <= 1'b0;
        end else begin
            if (press[fpc_pkg::FPC_K_FREEZE]) begin
                locked <= !locked;
                setup <= fpc_pkg::FPC_SET_NONE;
            end else if (press[fpc_pkg::FPC_K_RECIPE]) begin
                // Entering one setup mode drops the other.
                setup <= (setup == fpc_pkg::FPC_SET_RECIPE) ? fpc_pkg::FPC_SET_NONE
                                                           : fpc_pkg::FPC_SET_RECIPE;
            end else if (press[fpc_pkg::FPC_K_GLOBAL]) begin
                setup <= (setup == fpc_pkg::FPC_SET_GLOBAL) ? fpc_pkg::FPC_SET_NONE
                                                           : fpc_pkg::FPC_SET_GLOBAL;
            end
            if (press[fpc_pkg::FPC_K_START]) output_on_cmd <= 1'b1;
            else if (press[fpc_pkg::FPC_K_STOP]) output_on_cmd <= 1'b0;
        end
    end

    // ==========================================================
    // Views and setup parameters.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            line_view <= 2'b00;
            readout_select_key_view <= 2'b00;
            range_high <= 1'b1;
            parm_sel <= 8'h00;
            parm_val <= 8'h00;
            status_sel <= 2'b00;
        end else begin
            if (press[fpc_pkg::FPC_K_LINE]) line_view <= line_view + 2'b01;
            if (press[fpc_pkg::FPC_K_READOUT]) readout_select_key_view <= readout_select_key_view + 2'b01;
            if (press[fpc_pkg::FPC_K_RANGE]) range_high <= !range_high;
            if (setup != fpc_pkg::FPC_SET_NONE) begin
                if (press[fpc_pkg::FPC_K_VUP] && parm_sel != `FPC_PARM_MAX)
                    parm_sel <= parm_sel + 8'h01;
                else if (press[fpc_pkg::FPC_K_VDN] && parm_sel != 8'h00)
                    parm_sel <= parm_sel - 8'h01;
                if (press[fpc_pkg::FPC_K_CUP]) parm_val <= parm_val + 8'h01;
                else if (press[fpc_pkg::FPC_K_CDN]) parm_val <= parm_val - 8'h01;
            end else begin
                if (press[fpc_pkg::FPC_K_CUP] || press[fpc_pkg::FPC_K_CDN])
                    status_sel <= status_sel + 2'b01;
            end
        end
    end

    // ==========================================================
    // Frequency and current setpoints.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            freq_setpoint <= `FPC_FREQ_PRESET;
            curr_limit <= `FPC_CURR_MIN;
        end else begin
            if (press[fpc_pkg::FPC_K_F400]) begin
                freq_setpoint <= `FPC_FREQ_PRESET;
            end else if (press[fpc_pkg::FPC_K_FUP]) begin
                if (freq_setpoint < `FPC_FREQ_MAX)
                    freq_setpoint <= freq_setpoint + `FPC_FREQ_STEP;
            end else if (press[fpc_pkg::FPC_K_FDN]) begin
                if (freq_setpoint > `FPC_FREQ_MIN)
                    freq_setpoint <= freq_setpoint - `FPC_FREQ_STEP;
            end
            if (setup == fpc_pkg::FPC_SET_NONE) begin
                if (press[fpc_pkg::FPC_K_CUP] && curr_limit < curr_max)
                    curr_limit <= curr_limit + 16'h0001;
                else if (press[fpc_pkg::FPC_K_CDN] && curr_limit > `FPC_CURR_MIN)
                    curr_limit <= curr_limit - 16'h0001;
            end
        end
    end

    // ==========================================================
    // Voltage setpoint with hold-repeat, settle, flash and store.
    // The repeat period halves after each two repeats, down to one eighth.
    localparam int REP_CYC = `FPC_REPEAT_CYC;
    localparam int SET_CYC = `FPC_SETTLE_CYC;
    localparam int FLS_CYC = `FPC_FLASH_CYC;
    logic [26:0] rep_cnt;
    logic [2:0] rep_n;
    logic [28:0] settle_cnt;
    logic [26:0] flash_cnt;
    logic pending;
    logic vup_hold;
    logic vdn_hold;
    logic vstep;
    logic [26:0] rep_period;
    logic [15:0] vmax;

    assign vup_hold = key_db[fpc_pkg::FPC_K_VUP] && !locked && setup == fpc_pkg::FPC_SET_NONE;
    assign vdn_hold = key_db[fpc_pkg::FPC_K_VDN] && !locked && setup == fpc_pkg::FPC_SET_NONE;
    assign rep_period = 27'(REP_CYC) >> rep_n[2:1];
    assign vmax = range_high ? `FPC_VOLT_MAX_HI : `FPC_VOLT_MAX_LO;
    assign vstep = (vup_hold ^ vdn_hold) && rep_cnt == 27'h000_0000;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rep_cnt <= 27'h000_0000;
            rep_n <= 3'b000;
        end else if (!(vup_hold ^ vdn_hold)) begin
            rep_cnt <= 27'h000_0000;
            rep_n <= 3'b000;
        end else if (rep_cnt == rep_period - 27'h000_0001) begin
            rep_cnt <= 27'h000_0000;
            if (rep_n != 3'b111) rep_n <= rep_n + 3'b001;
        end else begin
            rep_cnt <= rep_cnt + 27'h000_0001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            volt_setpoint <= `FPC_VOLT_RESET;
            volt_stored <= `FPC_VOLT_RESET;
            pending <= 1'b0;
            settle_cnt <= 29'h0000_0000;
            flash_cnt <= 27'h000_0000;
            volt_blank <= 1'b0;
        end else begin
            if (vstep) begin
                if (vup_hold && volt_setpoint < vmax) volt_setpoint <= volt_setpoint + 16'h0001;
                if (vdn_hold && volt_setpoint != 16'h0000) volt_setpoint <= volt_setpoint - 16'h0001;
                pending <= 1'b1;
                settle_cnt <= 29'h0000_0000;
            end else if (pending && settle_cnt == 29'(SET_CYC - 1)) begin
                pending <= 1'b0;
                volt_stored <= volt_setpoint;
                flash_cnt <= 27'(FLS_CYC);
            end else if (pending) begin
                settle_cnt <= settle_cnt + 29'h0000_0001;
            end
            if (flash_cnt != 27'h000_0000) flash_cnt <= flash_cnt - 27'h000_0001;
            volt_blank <= flash_cnt != 27'h000_0000;
        end
    end

    // ==========================================================
    // Lamps and display selection, all registered.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lamp_output_on <= 1'b0;
            lamp_fault <= 1'b0;
            lamp_trip <= 1'b0;
            lamp_line <= 4'h1;
            lamp_low_range <= 1'b0;
            lamp_high_range <= 1'b1;
            lamp_frozen <= 1'b0;
            lamp_external <= 1'b0;
            lamp_manual <= 1'b0;
            lamp_recipe <= 1'b0;
            lamp_global <= 1'b0;
            lamp_readout <= 4'h1;
            freq_disp_sel <= 2'b00;
        end else begin
            lamp_output_on <= output_on_cmd && act_s2 && !ctrl[`FPC_CTRL_FAULT];
            lamp_fault <= ctrl[`FPC_CTRL_FAULT];
            lamp_trip <= ctrl[`FPC_CTRL_TRIP];
            lamp_line <= 4'h1 << line_view;
            lamp_low_range <= !range_high;
            lamp_high_range <= range_high;
            lamp_frozen <= locked;
            lamp_external <= ctrl[`FPC_CTRL_EXT];
            lamp_manual <= ctrl[`FPC_CTRL_MANUAL];
            lamp_recipe <= setup == fpc_pkg::FPC_SET_RECIPE;
            lamp_global <= setup == fpc_pkg::FPC_SET_GLOBAL;
            lamp_readout <= 4'h1 << readout_select_key_view;
            // Error text outranks setup parameters; 0 value, 1 parameters, 2 error.
            if (ctrl[`FPC_CTRL_FAULT]) freq_disp_sel <= 2'b10;
            else if (setup != fpc_pkg::FPC_SET_NONE) freq_disp_sel <= 2'b01;
            else freq_disp_sel <= 2'b00;
        end
    end

    // ==========================================================
    // APB read side: zero wait states, unmapped reads return zero with an error.
    logic mapped;
    assign mapped = paddr <= `FPC_ADDR_PARM && paddr[1:0] == 2'b00;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `FPC_ADDR_CTRL: prdata <= {28'h000_0000, ctrl};
                    `FPC_ADDR_FREQ: prdata <= {16'h0000, freq_setpoint};
                    `FPC_ADDR_VOLT: prdata <= {volt_stored, volt_setpoint};
                    `FPC_ADDR_CURR: prdata <= {curr_max, curr_limit};
                    `FPC_ADDR_STAT: prdata <= {16'h0000, readout_select_key_view, line_view, status_sel, setup,
                                               2'b00, pending, range_high, 1'b0, locked,
                                               output_on_cmd, act_s2};
                    `FPC_ADDR_KEYS: prdata <= {16'h0000, key_db};
                    `FPC_ADDR_PARM: prdata <= {16'h0000, parm_val, parm_sel};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Checks.
    chk_freq_bounds: assert property (@(posedge clock) disable iff (!rst_b)
        freq_setpoint >= `FPC_FREQ_MIN && freq_setpoint <= `FPC_FREQ_MAX)
        else $error("frequency setpoint out of bounds");
    chk_preset_load: assert property (@(posedge clock) disable iff (!rst_b)
        press[fpc_pkg::FPC_K_F400] |=> freq_setpoint == `FPC_FREQ_PRESET)
        else $error("preset did not load 400");
    chk_freq_step: assert property (@(posedge clock) disable iff (!rst_b)
        press[fpc_pkg::FPC_K_FUP] && !press[fpc_pkg::FPC_K_F400] && freq_setpoint < `FPC_FREQ_MAX
        |=> freq_setpoint == $past(freq_setpoint) + `FPC_FREQ_STEP)
        else $error("frequency up step wrong");
    chk_lock_lamp: assert property (@(posedge clock) disable iff (!rst_b)
        press[fpc_pkg::FPC_K_FREEZE] |=> ##1 lamp_frozen == locked)
        else $error("lock lamp mismatch");
    chk_line_onehot: assert property (@(posedge clock) disable iff (!rst_b)
        $onehot(lamp_line) && $onehot(lamp_readout))
        else $error("view lamps not one-hot");
    chk_setup_excl: assert property (@(posedge clock) disable iff (!rst_b)
        !(lamp_recipe && lamp_global))
        else $error("both setup lamps lit");
    chk_range_lamps: assert property (@(posedge clock) disable iff (!rst_b)
        press[fpc_pkg::FPC_K_RANGE] |=> ##1 lamp_low_range != $past(lamp_low_range, 2))
        else $error("range toggle not shown");
    sequence s_stored;
        pending && settle_cnt == 29'(SET_CYC - 1) && !vstep;
    endsequence
    chk_store_flash: assert property (@(posedge clock) disable iff (!rst_b)
        s_stored |=> volt_stored == $past(volt_setpoint) ##1 volt_blank)
        else $error("voltage not stored and flashed");
endmodule // fpc_panel
`default_nettype wire

// ---- tb/fpc_keypad.sv ----
`default_nettype none
// ==========================================================
// Key pad model: one key held closed, then open, for HOLD cycles each.
module fpc_keypad #(
    parameter int HOLD = 2050
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_b,
    // Press request.
    input wire logic [3:0] press_idx,
    input wire logic press_go,
    // Key levels and progress.
    output logic [15:0] keys,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] count;
    // The release is held as long as the press, so debounce sees both edges clean.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            keys <= 16'h0000;
            busy <= 1'b0;
            count <= 13'h0000;
        end else if (press_go && !busy) begin
            keys <= 16'h0001 << press_idx;
            busy <= 1'b1;
            count <= 13'h0000;
        end else if (busy) begin
            count <= count + 13'h0001;
            if (count == 13'(HOLD - 1)) begin
                keys <= 16'h0000;
            end
            if (count == 13'(2 * HOLD - 1)) begin
                busy <= 1'b0;
            end
        end
    end
endmodule // fpc_keypad
`default_nettype wire

// ---- tb/tb_top.sv ----
`include "fpc_defines.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] key; logic [15:0] freq; logic [12:0] st;} fpc_row_t;
    logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, go = 0, output_active = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er, busy, volt_blank, output_on_cmd, range_high;
    logic [3:0] idx = 4'h0, lamp_line, lamp_readout;
    logic [15:0] keys, freq_setpoint, volt_setpoint, volt_stored, curr_limit;
    logic [1:0] freq_disp_sel;
    logic lamp_output_on, lamp_fault, lamp_trip, lamp_low_range, lamp_high_range, lamp_frozen;
    logic lamp_external, lamp_manual, lamp_recipe, lamp_global;
    int fails = 0, checks = 0, cycles = 0;
    fpc_row_t rows[12] = '{
        '{4'h2, 16'h0191, 13'h1088}, '{4'h2, 16'h0192, 13'h1088}, '{4'h1, 16'h0191, 13'h1088},
        '{4'h0, 16'h0190, 13'h1088}, '{4'h4, 16'h0190, 13'h0888}, '{4'h3, 16'h0190, 13'h0908},
        '{4'h3, 16'h0190, 13'h0a08}, '{4'h3, 16'h0190, 13'h0c08}, '{4'h3, 16'h0190, 13'h0888},
        '{4'hC, 16'h0190, 13'h0890}, '{4'h9, 16'h0190, 13'h0892}, '{4'hA, 16'h0190, 13'h0891}};
    always #2.5 clock = ~clock;
    fpc_panel u_fpc_panel (.*);
    fpc_keypad u_fpc_keypad (.clock(clock), .rst_b(rst_b), .press_idx(idx), .press_go(go), .keys(keys),
        .busy(busy));
    // ==========================================================
    // Shared tasks.
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic press(input logic [3:0] k);
        @(posedge clock);
        go <= 1'b1;
        idx <= k;
        @(posedge clock);
        go <= 1'b0;
        // Busy only reads high from the edge after the keypad has taken the request.
        do @(posedge clock); while (busy === 1'b1);
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            fails++;
            report_and_stop();
        end
    end
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check("freq", 32'(freq_setpoint), 32'h0000_0190);
        check("lamps", 32'({range_high, lamp_line, lamp_readout, lamp_output_on}), 32'h0000_0222);
        $display("reset test done");
        foreach (rows[i]) begin
            press(rows[i].key);
            check("freq", 32'(freq_setpoint), 32'(rows[i].freq));
            check("view", 32'({range_high, lamp_low_range, lamp_line, lamp_readout, output_on_cmd, lamp_recipe,
                lamp_global}), 32'(rows[i].st));
            check("high", 32'(lamp_high_range), 32'(rows[i].st[12]));
            $display("row %0d done", i);
        end
        check("disp", 32'(freq_disp_sel), 32'h0000_0001);
        press(4'hD);
        check("out", 32'({output_on_cmd, lamp_output_on}), 32'h0000_0003);
        @(posedge clock);
        output_active <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check("active", 32'(lamp_output_on), 32'h0000_0000);
        @(posedge clock);
        output_active <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check("active", 32'(lamp_output_on), 32'h0000_0001);
        press(4'hB);
        check("frozen", 32'({lamp_frozen, lamp_global}), 32'h0000_0002);
        press(4'h2);
        check("freq", 32'(freq_setpoint), 32'h0000_0190);
        press(4'hB);
        check("frozen", 32'({lamp_frozen, freq_disp_sel}), 32'h0000_0000);
        press(4'hE);
        check("out", 32'({output_on_cmd, lamp_output_on}), 32'h0000_0000);
        press(4'h6);
        check("volt", {volt_stored, volt_setpoint}, 32'h0000_0001);
        check("blank", 32'(volt_blank), 32'h0000_0000);
        press(4'h8);
        check("curr", 32'(curr_limit), 32'h0000_0002);
        $display("lock test done");
        apb(1'b1, `FPC_ADDR_CTRL, 32'h0000_000F);
        @(posedge clock);
        #1;
        check("ctrl", 32'({lamp_fault, lamp_trip, lamp_external, lamp_manual}), 32'h0000_000F);
        check("disp", 32'(freq_disp_sel), 32'h0000_0002);
        apb(1'b0, `FPC_ADDR_FREQ, 32'h0000_0000);
        check("freq rd", rd, 32'h0000_0190);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check("unmapped", {rd[30:0], er}, 32'h0000_0001);
        apb(1'b1, `FPC_ADDR_CTRL, 32'h0000_0002);
        @(posedge clock);
        #1;
        check("ctrl", 32'({lamp_fault, lamp_trip, lamp_external, lamp_manual}), 32'h0000_0004);
        $display("register test done");
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
